// File: tb/cwtc_host_model.sv
// Purpose: host model issuing register strobes and charge setting writes
// Assumes: requests change just after a rising edge and hold until taken
// Notes: released address and data lines show the inverse of the last value
`timescale 1ns/1ns
module cwtc_host_model (
  input wire logic clk,
  input wire logic [7:0] reg_rd_data,
  input wire logic reg_rd_valid,
  output logic reg_wr,
  output logic reg_rd,
  output logic [7:0] reg_addr,
  output logic [7:0] reg_wdata,
  output logic charge_voltage_write,
  output logic charge_current_write,
  output logic charge_settings_valid
);
  initial begin
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_addr = 8'h00;
    reg_wdata = 8'h00;
    charge_voltage_write = 1'b0;
    charge_current_write = 1'b0;
    charge_settings_valid = 1'b0;
  end
  ////////////////////////////////////////////////////////////////////////////////
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clk);
    reg_wr <= 1'b0;
    reg_addr <= ~a;
    reg_wdata <= ~d;
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] q);
    int k;
    @(posedge clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clk);
    reg_rd <= 1'b0;
    reg_addr <= ~a;
    k = 0;
    do begin
      @(posedge clk);
      k++;
    end while (reg_rd_valid !== 1'b1 && k < 4);
    // read data is due exactly one cycle after the strobe is taken
    q = (reg_rd_valid === 1'b1 && k == 1) ? reg_rd_data : 8'hXX;
  endtask
  task automatic charge(input logic cur, input logic ok);
    @(posedge clk);
    charge_current_write <= cur;
    charge_voltage_write <= ~cur;
    charge_settings_valid <= ok;
    @(posedge clk);
    charge_current_write <= 1'b0;
    charge_voltage_write <= 1'b0;
    charge_settings_valid <= ~ok;
  endtask
  // gap kept below the selected period so charging stays active
  task automatic keep_alive(input int n, input int gap);
    for (int i = 0; i < n; i++) begin
      charge(i[0], 1'b1);
      repeat (gap) @(posedge clk);
    end
  endtask
endmodule // cwtc_host_model

// File: tb/tb.sv
// Purpose: self-checking bench for the charger watchdog and trim control
// Assumes: shortened watchdog counts, converter answers 4 cycles after enable
// Notes: watchdog expiry is checked in a window; each period write also clears the prescaler phase
`timescale 1ns/1ns
module tb;
  localparam int TK = 4;
  logic clk, rst_n, reg_wr, reg_rd, charge_voltage_write, charge_current_write;
  logic charge_settings_valid, converter_request, converter_running;
  logic forced_gain_trim_enable, forced_time_constant_enable;
  logic [7:0] reg_addr, reg_wdata, reg_rd_data, limit_setting_pin, host_input_limit;
  logic [7:0] input_current_limit, q;
  logic [5:0] adaptive_gain_trim_auto, forced_gain_trim_value, a, v;
  logic reg_rd_valid, converter_enable, skip_auto_calibration, charge_suspend;
  logic restore_defaults;
  logic [2:0] dly;
  int n_fail, compares, m_ext, m_per, n, tk;
  ////////////////////////////////////////////////////////////////////////////////
  cwtc_top #(.WD_TICK_CYCLES(TK), .WD_SHORT_TICKS(5), .WD_MID_TICKS(8),
    .WD_LONG_TICKS(12), .LIMIT_W(8)) cwtc_top_inst (.clk, .rst_n, .reg_wr, .reg_rd,
    .reg_addr, .reg_wdata, .charge_voltage_write, .charge_current_write,
    .charge_settings_valid, .converter_request, .converter_running,
    .adaptive_gain_trim_auto, .forced_gain_trim_value, .forced_gain_trim_enable,
    .forced_time_constant_enable, .limit_setting_pin, .host_input_limit, .reg_rd_data,
    .reg_rd_valid, .converter_enable, .skip_auto_calibration, .charge_suspend,
    .restore_defaults, .input_current_limit);
  cwtc_host_model cwtc_host_model_inst (.clk, .reg_rd_data, .reg_rd_valid, .reg_wr,
    .reg_rd, .reg_addr, .reg_wdata, .charge_voltage_write, .charge_current_write,
    .charge_settings_valid);
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  // converter starts switching a few cycles after it is enabled
  always @(posedge clk) begin
    dly <= {dly[1:0], converter_enable};
    converter_running <= dly[2];
  end
  function automatic logic [7:0] exp80();
    return 8'((m_ext << 4) | m_per);
  endfunction
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      n_fail++;
      $display("MISMATCH at %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic summarize;
    $display("compares %0d n_fail %0d", compares, n_fail);
    if (n_fail == 0 && compares > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  task automatic count_low(input int cyc);
    n = 0;
    repeat (cyc) begin
      @(posedge clk);
      n += (converter_enable === 1'b0);
    end
  endtask
  initial begin
    #60000;
    n_fail++;
    summarize;
  end
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    rst_n = 1'b0;
    dly = 3'h0;
    converter_running = 1'b0;
    converter_request = 1'b1;
    adaptive_gain_trim_auto = 6'h00;
    forced_gain_trim_value = 6'h00;
    forced_gain_trim_enable = 1'b0;
    forced_time_constant_enable = 1'b0;
    limit_setting_pin = 8'h00;
    host_input_limit = 8'h00;
    n_fail = 0;
    compares = 0;
    m_ext = 1;
    m_per = 3;
    void'($urandom(71275));
    repeat (8) @(posedge clk);
    rst_n <= 1'b1;
    cwtc_host_model_inst.rd(8'h80, q);
    check(q, exp80());
    cwtc_host_model_inst.rd(8'h65, q);
    check(q, 8'h00);
    cwtc_host_model_inst.rd(8'h42, q);
    check(q, 8'h00);
    $display("test reset_values done");
    for (int i = 0; i < 8; i++) begin
      m_ext = i % 2;
      m_per = 0;
      cwtc_host_model_inst.wr(8'h80, exp80());
      limit_setting_pin <= 8'($urandom);
      host_input_limit <= 8'($urandom);
      repeat (6) @(posedge clk);
      check(input_current_limit, (m_ext == 0) ? host_input_limit :
        (limit_setting_pin < host_input_limit ? limit_setting_pin : host_input_limit));
    end
    $display("test input_limit done");
    for (int i = 0; i < 2; i++) begin
      forced_time_constant_enable <= i[0];
      repeat (2) @(posedge clk);
      check(skip_auto_calibration, i[0]);
    end
    a = 6'($urandom);
    v = 6'($urandom % 63);
    adaptive_gain_trim_auto <= a;
    repeat (8) @(posedge clk);
    cwtc_host_model_inst.rd(8'h65, q);
    check(q, {a, 2'b00});
    converter_request <= 1'b0;
    repeat (8) @(posedge clk);
    cwtc_host_model_inst.rd(8'h65, q);
    check(q, 8'h00);
    forced_gain_trim_value <= v;
    forced_gain_trim_enable <= 1'b1;
    converter_request <= 1'b1;
    repeat (8) @(posedge clk);
    adaptive_gain_trim_auto <= ~a;
    repeat (3) @(posedge clk);
    cwtc_host_model_inst.rd(8'h65, q);
    check(q, {6'(v + 6'h01), 2'b00});
    forced_gain_trim_enable <= 1'b0;
    $display("test gain_trim done");
    // second load write lands while the first is still running
    cwtc_host_model_inst.wr(8'h65, 8'h02);
    cwtc_host_model_inst.wr(8'h65, 8'h02);
    count_low(40);
    check(n, 14);
    cwtc_host_model_inst.rd(8'h65, q);
    check(q, {~a, 2'b00});
    cwtc_host_model_inst.wr(8'h65, 8'h00);
    count_low(20);
    check(n, 0);
    $display("test forced_load done");
    for (m_per = 1; m_per < 4; m_per++) begin
      tk = (m_per == 1) ? 5 : (m_per == 2) ? 8 : 12;
      cwtc_host_model_inst.wr(8'h80, exp80());
      n = 0;
      while (charge_suspend !== 1'b1 && n < 200) begin
        @(posedge clk);
        n++;
      end
      check(n >= tk * TK - TK - 2 && n <= tk * TK + TK + 4, 1);
      cwtc_host_model_inst.charge(1'b0, 1'b0);
      repeat (3) @(posedge clk);
      check(charge_suspend, 1'b1);
      cwtc_host_model_inst.charge(1'b1, 1'b1);
      repeat (3) @(posedge clk);
      check(charge_suspend, 1'b0);
    end
    m_per = 0;
    cwtc_host_model_inst.wr(8'h80, exp80());
    repeat (100) @(posedge clk);
    check(charge_suspend, 1'b0);
    $display("test watchdog_periods done");
    m_per = 1;
    repeat (5) begin
      repeat (12) @(posedge clk);
      cwtc_host_model_inst.wr(8'h80, exp80() | 8'h04);
    end
    check(charge_suspend, 1'b0);
    cwtc_host_model_inst.rd(8'h80, q);
    check(q, exp80());
    cwtc_host_model_inst.keep_alive(6, 12);
    check(charge_suspend, 1'b0);
    repeat (40) @(posedge clk);
    cwtc_host_model_inst.wr(8'h80, exp80() | 8'h04);
    repeat (3) @(posedge clk);
    check(charge_suspend, 1'b1);
    cwtc_host_model_inst.charge(1'b0, 1'b1);
    repeat (3) @(posedge clk);
    check(charge_suspend, 1'b0);
    $display("test watchdog_restart done");
    cwtc_host_model_inst.wr(8'h80, 8'h00);
    cwtc_host_model_inst.wr(8'h80, 8'h80);
    n = 0;
    repeat (6) begin
      @(posedge clk);
      n += (restore_defaults === 1'b1);
    end
    check(n, 1);
    m_ext = 1;
    m_per = 3;
    cwtc_host_model_inst.rd(8'h80, q);
    check(q, exp80());
    $display("test restore done");
    summarize;
  end
endmodule // tb

// File: verilog/cwtc_pkg.sv
// Purpose: constants and types shared by the charger watchdog and trim control block
// Assumes: one 125 MHz core clock, registers written over a simple byte-wide port
// Notes: long watchdog counts are top-level parameters, defaults derived here
// Function
// [R1] gain trim readback reads zero while the converter is shut off
// [R2] start of switching with forced enable fixes readback at forced value plus one
// [R3] zero-to-one write of load bit shuts the converter off, then restarts it
// [R4] after the single load the converter resumes and the load bit clears itself
// [R5] restore bit writes every register back to its default value
// [R6] limit is host limit, or lower of pin and host when external enable set
// [R7] watchdog restart bit restarts the timer and then returns to zero
// [R8] period field: 00 off, 01 5 s, 10 88 s, 11 175 s; resets to 11
// [R9] no charge setting write within the period suspends charging at zero current
// [R10] after expiry, setting writes, period write or restart bit restart the timer
// [R11] after expiry, charging resumes only when newly written settings are valid
// [R12] host writes charge settings more often than the selected period
// [R13] forced time-constant enable makes restarts use forced values, skip calibration
// [R14] repeated one or a zero written to the load bit starts nothing
package cwtc_pkg;

  localparam logic [7:0] ADDR_GAIN_TRIM = 8'h65;
  localparam logic [7:0] ADDR_VCTRL = 8'h80;

  // gain trim register fields
  localparam int GT_READBACK_LSB = 2;
  localparam int GT_UPDATE_BIT = 1;

  // virtual control register fields
  localparam int VC_RESTORE_BIT = 7;
  localparam int VC_EXT_LIMIT_BIT = 4;
  localparam int VC_WD_RESTART_BIT = 2;
  localparam int VC_PERIOD_LSB = 0;

  localparam logic [7:0] GAIN_TRIM_RESET = 8'h00;
  localparam logic [7:0] VCTRL_RESET = 8'h13;
  localparam logic RESET_EXT_LIMIT = 1'b1;
  localparam logic [1:0] RESET_PERIOD = 2'h3;

  localparam logic [1:0] PERIOD_OFF = 2'h0;
  localparam logic [1:0] PERIOD_SHORT = 2'h1;
  localparam logic [1:0] PERIOD_MID = 2'h2;
  localparam logic [1:0] PERIOD_LONG = 2'h3;

  // timing: one watchdog tick per millisecond
  localparam int CLK_PERIOD_NS = 8;
  localparam int WD_TICK_NS = 1000000;
  localparam int WD_TICK_CYCLES = (WD_TICK_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int MS_PER_S = 1000;
  localparam int WD_SHORT_S = 5;
  localparam int WD_MID_S = 88;
  localparam int WD_LONG_S = 175;
  localparam int WD_SHORT_TICKS = WD_SHORT_S * MS_PER_S;
  localparam int WD_MID_TICKS = WD_MID_S * MS_PER_S;
  localparam int WD_LONG_TICKS = WD_LONG_S * MS_PER_S;

  // converter held off this long during a forced-trim load
  localparam int UPD_OFF_NS = 128;
  localparam int UPD_OFF_CYCLES = (UPD_OFF_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  typedef enum logic [1:0] {
    UPD_IDLE,
    UPD_OFF,
    UPD_WAIT
  } cwtc_upd_t;

endpackage

// File: verilog/cwtc_top.sv
// Purpose: watchdog, register restore, input-limit select and forced-trim update
// Assumes: write/read strobes and converter status come from logic on clk
// Notes: limit pin is asynchronous and passes a two-flop synchroniser
`timescale 1ns/1ns
module cwtc_top #(
  parameter int WD_TICK_CYCLES = cwtc_pkg::WD_TICK_CYCLES,
  parameter int WD_SHORT_TICKS = cwtc_pkg::WD_SHORT_TICKS,
  parameter int WD_MID_TICKS = cwtc_pkg::WD_MID_TICKS,
  parameter int WD_LONG_TICKS = cwtc_pkg::WD_LONG_TICKS,
  parameter int LIMIT_W = 8
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic charge_voltage_write,
  input wire logic charge_current_write,
  input wire logic charge_settings_valid,
  input wire logic converter_request,
  input wire logic converter_running,
  input wire logic [5:0] adaptive_gain_trim_auto,
  input wire logic [5:0] forced_gain_trim_value,
  input wire logic forced_gain_trim_enable,
  input wire logic forced_time_constant_enable,
  input wire logic [LIMIT_W-1:0] limit_setting_pin,
  input wire logic [LIMIT_W-1:0] host_input_limit,
  output logic [7:0] reg_rd_data,
  output logic reg_rd_valid,
  output logic converter_enable,
  output logic skip_auto_calibration,
  output logic charge_suspend,
  output logic restore_defaults,
  output logic [LIMIT_W-1:0] input_current_limit
);

  function automatic logic wr_to(input logic wr, input logic [7:0] a, input logic [7:0] t);
    wr_to = wr && (a == t);
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // register writes

  logic wr_gain, wr_vctrl, restore_req;
  logic upd_start;
  logic update_bit, next_update_bit;
  logic ext_limit, next_ext_limit;
  logic wd_restart, next_wd_restart;
  logic [1:0] period, next_period;
  logic next_restore_defaults;
  cwtc_pkg::cwtc_upd_t upd_state, next_upd_state;

  assign wr_gain = wr_to(reg_wr, reg_addr, cwtc_pkg::ADDR_GAIN_TRIM);
  assign wr_vctrl = wr_to(reg_wr, reg_addr, cwtc_pkg::ADDR_VCTRL);
  assign restore_req = wr_vctrl && reg_wdata[cwtc_pkg::VC_RESTORE_BIT];
  // only a real zero-to-one edge starts a load
  assign upd_start = wr_gain && reg_wdata[cwtc_pkg::GT_UPDATE_BIT] && !update_bit // R3 R14
    && !restore_req;

  always_comb begin
    next_ext_limit = ext_limit;
    next_period = period;
    next_wd_restart = 1'b0; // R7
    next_restore_defaults = 1'b0;
    if (restore_req) begin // R5
      next_ext_limit = cwtc_pkg::RESET_EXT_LIMIT;
      next_period = cwtc_pkg::RESET_PERIOD;
      next_restore_defaults = 1'b1;
    end else if (wr_vctrl) begin
      next_ext_limit = reg_wdata[cwtc_pkg::VC_EXT_LIMIT_BIT];
      next_period = reg_wdata[cwtc_pkg::VC_PERIOD_LSB +: 2]; // R8
      next_wd_restart = reg_wdata[cwtc_pkg::VC_WD_RESTART_BIT]; // R7
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      ext_limit <= cwtc_pkg::RESET_EXT_LIMIT;
      period <= cwtc_pkg::RESET_PERIOD;
      wd_restart <= 1'b0;
      restore_defaults <= 1'b0;
    end else begin
      ext_limit <= next_ext_limit;
      period <= next_period;
      wd_restart <= next_wd_restart;
      restore_defaults <= next_restore_defaults;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // forced-trim load sequence

  localparam int OFF_W = $clog2(cwtc_pkg::UPD_OFF_CYCLES + 1);

  logic [OFF_W-1:0] off_cnt, next_off_cnt;

  always_comb begin
    next_upd_state = upd_state;
    next_update_bit = update_bit;
    next_off_cnt = off_cnt;
    unique case (upd_state)
      cwtc_pkg::UPD_IDLE: begin
        if (upd_start) begin // R3
          next_upd_state = cwtc_pkg::UPD_OFF;
          next_update_bit = 1'b1;
          next_off_cnt = '0;
        end
      end
      cwtc_pkg::UPD_OFF: begin
        // converter held off until the shutdown has settled
        next_off_cnt = off_cnt + 1'b1;
        if (off_cnt == OFF_W'(cwtc_pkg::UPD_OFF_CYCLES - 1)) begin // R3
          next_upd_state = cwtc_pkg::UPD_WAIT;
        end
      end
      cwtc_pkg::UPD_WAIT: begin
        if (converter_running) begin // R4
          next_upd_state = cwtc_pkg::UPD_IDLE;
          next_update_bit = 1'b0;
        end
      end
    endcase
    if (restore_req) begin // R5
      next_upd_state = cwtc_pkg::UPD_IDLE;
      next_update_bit = 1'b0;
    end
  end

  logic next_converter_enable;
  assign next_converter_enable = converter_request && (next_upd_state != cwtc_pkg::UPD_OFF);

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      upd_state <= cwtc_pkg::UPD_IDLE;
      update_bit <= 1'b0;
      off_cnt <= '0;
      converter_enable <= 1'b0;
    end else begin
      upd_state <= next_upd_state;
      update_bit <= next_update_bit;
      off_cnt <= next_off_cnt;
      converter_enable <= next_converter_enable; // R3 R4
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // gain trim readback and time-constant source

  logic running_d;
  logic forced_lock, next_forced_lock;
  logic [5:0] gain_trim, next_gain_trim;
  logic next_skip_auto_calibration;

  always_comb begin
    next_gain_trim = gain_trim;
    next_forced_lock = forced_lock;
    if (!converter_running || restore_req) begin // R1 R5
      next_gain_trim = '0;
      next_forced_lock = 1'b0;
    end else if (!running_d) begin
      next_forced_lock = forced_gain_trim_enable;
      next_gain_trim = forced_gain_trim_enable ? forced_gain_trim_value + 6'h01 // R2
        : adaptive_gain_trim_auto;
    end else if (!forced_lock) begin
      next_gain_trim = adaptive_gain_trim_auto;
    end
  end

  // sampled continuously so every restart sees the current enable
  assign next_skip_auto_calibration = forced_time_constant_enable; // R13

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      running_d <= 1'b0;
      forced_lock <= 1'b0;
      gain_trim <= '0;
      skip_auto_calibration <= 1'b0;
    end else begin
      running_d <= converter_running;
      forced_lock <= next_forced_lock;
      gain_trim <= next_gain_trim;
      skip_auto_calibration <= next_skip_auto_calibration;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // watchdog and charge suspend

  logic wd_kick, wd_expired;
  logic next_charge_suspend;

  // restore reloads the period and so restarts the timer as a period write
  assign wd_kick = charge_voltage_write || charge_current_write || wr_vctrl || wd_restart; // R10

  cwtc_watchdog #(
    .TICK_CYCLES(WD_TICK_CYCLES),
    .SHORT_TICKS(WD_SHORT_TICKS),
    .MID_TICKS(WD_MID_TICKS),
    .LONG_TICKS(WD_LONG_TICKS)
  ) u_watchdog (
    .clk(clk),
    .rst_n(rst_n),
    .restart(wd_kick),
    .period_sel(period),
    .expired(wd_expired)
  );

  always_comb begin
    next_charge_suspend = charge_suspend;
    if (wd_expired) begin // R9
      next_charge_suspend = 1'b1;
    end else if ((charge_voltage_write || charge_current_write) && charge_settings_valid) begin
      next_charge_suspend = 1'b0; // R11
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      charge_suspend <= 1'b0;
    end else begin
      charge_suspend <= next_charge_suspend;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // input current limit select

  logic [LIMIT_W-1:0] pin_meta, pin_sync;
  logic [LIMIT_W-1:0] next_input_current_limit;

  always_comb begin
    if (ext_limit && pin_sync < host_input_limit) begin // R6
      next_input_current_limit = pin_sync;
    end else begin
      next_input_current_limit = host_input_limit; // R6
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      pin_meta <= '0;
      pin_sync <= '0;
      input_current_limit <= '0;
    end else begin
      pin_meta <= limit_setting_pin;
      pin_sync <= pin_meta;
      input_current_limit <= next_input_current_limit;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // register reads

  logic [7:0] next_reg_rd_data;

  always_comb begin
    next_reg_rd_data = 8'h00;
    if (reg_addr == cwtc_pkg::ADDR_GAIN_TRIM) begin
      next_reg_rd_data = {gain_trim, update_bit, 1'b0};
    end else if (reg_addr == cwtc_pkg::ADDR_VCTRL) begin
      next_reg_rd_data = {1'b0, 2'h0, ext_limit, 1'b0, wd_restart, period};
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      reg_rd_data <= 8'h00;
      reg_rd_valid <= 1'b0;
    end else begin
      reg_rd_data <= reg_rd ? next_reg_rd_data : reg_rd_data;
      reg_rd_valid <= reg_rd;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // checks

  property p_gain_zero_off;
    @(posedge clk) disable iff (!rst_n)
      !converter_running |=> (gain_trim == 6'h00);
  endproperty
  a_gain_zero_off: assert property (p_gain_zero_off) // R1
    else $error("gain readback not zero while converter off");

  property p_gain_forced;
    @(posedge clk) disable iff (!rst_n)
      (converter_running && !running_d && forced_gain_trim_enable && !restore_req)
        |=> (gain_trim == $past(forced_gain_trim_value) + 6'h01);
  endproperty
  a_gain_forced: assert property (p_gain_forced) // R2
    else $error("forced gain readback is not forced value plus one");

  property p_load_shuts_off;
    @(posedge clk) disable iff (!rst_n)
      upd_start |=> !converter_enable [*2];
  endproperty
  a_load_shuts_off: assert property (p_load_shuts_off) // R3
    else $error("converter not shut off by forced-trim load");

  property p_load_resumes;
    @(posedge clk) disable iff (!rst_n)
      (upd_state == cwtc_pkg::UPD_WAIT && converter_running && !restore_req)
        |=> !update_bit && (upd_state == cwtc_pkg::UPD_IDLE);
  endproperty
  a_load_resumes: assert property (p_load_resumes) // R4
    else $error("load bit not cleared after restart");

  property p_restore;
    @(posedge clk) disable iff (!rst_n)
      restore_req |=> ext_limit && (period == cwtc_pkg::RESET_PERIOD) && !update_bit
        && restore_defaults;
  endproperty
  a_restore: assert property (p_restore) // R5
    else $error("restore did not return defaults");

  property p_limit_host;
    @(posedge clk) disable iff (!rst_n)
      !ext_limit |=> (input_current_limit == $past(host_input_limit));
  endproperty
  a_limit_host: assert property (p_limit_host) // R6
    else $error("limit differs from host limit with external limit off");

  property p_restart_clears;
    @(posedge clk) disable iff (!rst_n)
      // a fresh restart write in the same cycle legally sets the bit again
      (wd_restart && !(wr_vctrl && reg_wdata[cwtc_pkg::VC_WD_RESTART_BIT])) |=> !wd_restart;
  endproperty
  a_restart_clears: assert property (p_restart_clears) // R7
    else $error("watchdog restart bit did not self-clear");

  property p_expiry_suspends;
    @(posedge clk) disable iff (!rst_n)
      wd_expired |=> charge_suspend;
  endproperty
  a_expiry_suspends: assert property (p_expiry_suspends) // R9
    else $error("expiry did not suspend charging");

  property p_invalid_keeps_suspend;
    @(posedge clk) disable iff (!rst_n)
      (charge_suspend && !charge_settings_valid) |=> charge_suspend;
  endproperty
  a_invalid_keeps_suspend: assert property (p_invalid_keeps_suspend) // R11
    else $error("charging resumed without valid settings");

  property p_no_second_load;
    @(posedge clk) disable iff (!rst_n)
      (wr_gain && update_bit && upd_state == cwtc_pkg::UPD_OFF
        && off_cnt != OFF_W'(cwtc_pkg::UPD_OFF_CYCLES - 1))
        |=> (upd_state == cwtc_pkg::UPD_OFF) && (off_cnt == $past(off_cnt) + 1'b1);
  endproperty
  a_no_second_load: assert property (p_no_second_load) // R14
    else $error("repeated load write restarted the sequence");

endmodule // cwtc_top

// File: verilog/cwtc_watchdog.sv
// Purpose: watchdog timer with millisecond prescaler and selectable period
// Assumes: restart is a one-cycle pulse from the same clock, two cycles for a restart-bit write
// Notes: expired pulses once per timeout, then the timer holds until restarted
`timescale 1ns/1ns
module cwtc_watchdog #(
  parameter int TICK_CYCLES = cwtc_pkg::WD_TICK_CYCLES,
  parameter int SHORT_TICKS = cwtc_pkg::WD_SHORT_TICKS,
  parameter int MID_TICKS = cwtc_pkg::WD_MID_TICKS,
  parameter int LONG_TICKS = cwtc_pkg::WD_LONG_TICKS
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic restart,
  input wire logic [1:0] period_sel,
  output logic expired
);
  localparam int PW = $clog2(TICK_CYCLES + 1);
  localparam int CW = $clog2(LONG_TICKS + 1);

  logic [PW-1:0] pre_cnt, next_pre_cnt;
  logic [CW-1:0] tick_cnt, next_tick_cnt;
  logic done, next_done;
  logic next_expired;
  logic [CW-1:0] limit;
  logic tick;

  always_comb begin
    unique case (period_sel)
      cwtc_pkg::PERIOD_SHORT: limit = CW'(SHORT_TICKS); // R8
      cwtc_pkg::PERIOD_MID: limit = CW'(MID_TICKS); // R8
      cwtc_pkg::PERIOD_LONG: limit = CW'(LONG_TICKS); // R8
      cwtc_pkg::PERIOD_OFF: limit = '0;
    endcase
  end

  assign tick = (pre_cnt == PW'(TICK_CYCLES - 1));

  always_comb begin
    next_pre_cnt = pre_cnt;
    next_tick_cnt = tick_cnt;
    next_done = done;
    next_expired = 1'b0;
    if (restart || period_sel == cwtc_pkg::PERIOD_OFF) begin // R8 R10
      next_pre_cnt = '0;
      next_tick_cnt = '0;
      next_done = 1'b0;
    end else if (!done) begin
      next_pre_cnt = tick ? '0 : pre_cnt + 1'b1;
      if (tick) begin
        next_tick_cnt = tick_cnt + 1'b1;
        if (tick_cnt == limit - 1'b1) begin // R9
          next_done = 1'b1;
          next_expired = 1'b1;
        end
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      pre_cnt <= '0;
      tick_cnt <= '0;
      done <= 1'b0;
      expired <= 1'b0;
    end else begin
      pre_cnt <= next_pre_cnt;
      tick_cnt <= next_tick_cnt;
      done <= next_done;
      expired <= next_expired;
    end
  end

  property p_off_never_expires;
    @(posedge clk) disable iff (!rst_n)
      (period_sel == cwtc_pkg::PERIOD_OFF) |=> !expired;
  endproperty
  a_off_never_expires: assert property (p_off_never_expires) // R8
    else $error("watchdog expired while disabled");

endmodule // cwtc_watchdog
